// ===== logic/cpu_interrupt_response.sv
// interrupt acceptance, enable flops, halt exit and response sequencer
// ****************
// What this block does
// - unmaskable request sampled with maskable, wins always
// - unmaskable: read-like cycle, push, go 0066H
// - halted: fetch, substitute no-op, halt ack held
// - halted: sample at T4, exit next edge
// - both at halt exit: unmaskable acknowledged
// - stopped clock freezes all state intact
// - reset clears primary and shadow enables
// - enable sets both, disable clears both
// - after enable, refuse until next instruction done
// - maskable taken only with primary enable set
// - maskable accept clears both enables
// - unmaskable accept clears primary, keeps shadow
// - load from vector base/refresh copies shadow
// - unmaskable return copies shadow into primary
// - mode zero executes peripheral byte, two waits
// - reset selects mode zero
// - mode one pushes, goes 0038H
// - mode two pointer: vector base, peripheral byte with bit 0 cleared
// - reset clears vector base, accumulator loads it
// - mode two: push, read table low first, jump
// - mode two takes 19 clocks: 7, 6, 6
// - sample maskable at instruction end, not during bus request
// - maskable ack: io strobe, two waits inserted
// ****************
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_response
  import irq_resp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // request pins
  input wire logic int_n,
  input wire logic nmi_n,
  input wire logic bus_request_n,
  input wire logic [7:0] data_in,
  // core timing
  input wire logic instr_last,
  input wire logic t4_strobe,
  // decoded instructions
  input wire logic halt_exec,
  input wire logic enable_irq_instruction,
  input wire logic disable_irq_instruction,
  input wire logic return_from_unmaskable_service,
  input wire logic load_acc_from_vector_base,
  input wire logic load_acc_from_refresh_counter,
  input wire logic load_vector_base,
  input wire logic [7:0] acc_in,
  input wire logic mode_set,
  input wire logic [1:0] mode_sel,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // bus cycle control
  output logic halt_ack_n,
  output logic force_nop,
  output logic opcode_fetch_cycle,
  output logic io_request_strobe_n,
  output logic memory_request_strobe_n,
  output logic resp_busy,
  // response to core
  output logic stack_push,
  output logic table_read,
  output logic [15:0] table_addr,
  output logic [7:0] exec_byte,
  output logic exec_valid,
  output logic jump_valid,
  output logic [15:0] service_addr,
  output logic pv_flag,
  output logic pv_load
);

  // ****************
  // state
  // ****************
  resp_state_t state_r;
  logic [3:0] cnt_r, ack_len;
  logic kind_nmi_r, halted_r, enable_delay_r;
  logic primary_enable_flop_r, shadow_enable_flop_r;
  logic nmi_n_d_r, nmi_pend_r;
  logic [7:0] vbase_r, exec_byte_r, reg_rdata_r;
  logic [1:0] mode_r;
  logic [15:0] table_addr_r, service_addr_r;
  logic exec_valid_r, pv_flag_r, pv_load_r;
  logic sample, take_nmi, take_int, ack_last;

  // ****************
  // acceptance
  // ****************
  assign sample = (state_r == ST_IDLE) && (halted_r ? t4_strobe : instr_last);
  assign take_nmi = sample && nmi_pend_r;
  assign take_int = sample && !nmi_pend_r && !int_n && primary_enable_flop_r
    && bus_request_n && !enable_delay_r && !enable_irq_instruction;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nmi_n_d_r <= 1'b1;
      nmi_pend_r <= 1'b0;
    end
    else
    begin
      nmi_n_d_r <= nmi_n;
      if (nmi_n_d_r && !nmi_n)
        nmi_pend_r <= 1'b1;
      else if (take_nmi)
        nmi_pend_r <= 1'b0;
    end
  end

  // ****************
  // enable flops
  // ****************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primary_enable_flop_r <= 1'b0;
      shadow_enable_flop_r <= 1'b0;
    end
    else if (take_int || disable_irq_instruction)
    begin
      primary_enable_flop_r <= 1'b0;
      shadow_enable_flop_r <= 1'b0;
    end
    else if (take_nmi)
      primary_enable_flop_r <= 1'b0;
    else if (enable_irq_instruction)
    begin
      primary_enable_flop_r <= 1'b1;
      shadow_enable_flop_r <= 1'b1;
    end
    else if (return_from_unmaskable_service)
      primary_enable_flop_r <= shadow_enable_flop_r;
  end

  // one-instruction shadow after enable
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      enable_delay_r <= 1'b0;
    else if (enable_irq_instruction)
      enable_delay_r <= 1'b1;
    else if (instr_last)
      enable_delay_r <= 1'b0;
  end

  // parity/overflow copy of shadow flop
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pv_flag_r <= 1'b0;
      pv_load_r <= 1'b0;
    end
    else
    begin
      pv_load_r <= load_acc_from_vector_base || load_acc_from_refresh_counter;
      if (load_acc_from_vector_base || load_acc_from_refresh_counter)
        pv_flag_r <= shadow_enable_flop_r;
    end
  end

  // ****************
  // halt
  // ****************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      halted_r <= 1'b0;
    else if (take_nmi || take_int)
      halted_r <= 1'b0;
    else if (halt_exec)
      halted_r <= 1'b1;
  end

  // ****************
  // vector base and mode
  // ****************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      vbase_r <= VBASE_RST;
    else if (load_vector_base)
      vbase_r <= acc_in;
    else if (reg_wr && reg_addr == REG_VBASE)
      vbase_r <= reg_wdata;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= MODE_RST;
    else if (mode_set && mode_sel != 2'h3)
      mode_r <= mode_sel;
    else if (reg_wr && reg_addr == REG_MODE && reg_wdata[1:0] != 2'h3)
      mode_r <= reg_wdata[1:0];
  end

  // ****************
  // response sequencer
  // ****************
  assign ack_len = kind_nmi_r ? ACK_NMI_CYC : ACK_INT_CYC;
  assign ack_last = (state_r == ST_ACK) && (cnt_r == ack_len - 4'h1);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      kind_nmi_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 4'h1;
      case (state_r)
        ST_IDLE:
        begin
          cnt_r <= 4'h0;
          if (take_nmi || take_int)
          begin
            state_r <= ST_ACK;
            kind_nmi_r <= take_nmi;
          end
        end
        ST_ACK:
        begin
          if (ack_last)
          begin
            cnt_r <= 4'h0;
            state_r <= (!kind_nmi_r && mode_r == MODE0) ? ST_IDLE : ST_PUSH;
          end
        end
        ST_PUSH:
        begin
          if (cnt_r == PUSH_CYC - 4'h1)
          begin
            cnt_r <= 4'h0;
            state_r <= (!kind_nmi_r && mode_r == MODE2) ? ST_TABLE : ST_JUMP;
          end
        end
        ST_TABLE:
        begin
          if (cnt_r == TABLE_CYC - 4'h1)
          begin
            cnt_r <= 4'h0;
            state_r <= ST_JUMP;
          end
        end
        default:
        begin
          cnt_r <= 4'h0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      service_addr_r <= 16'h0000;
      table_addr_r <= 16'h0000;
      exec_byte_r <= 8'h00;
      exec_valid_r <= 1'b0;
    end
    else
    begin
      exec_valid_r <= ack_last && !kind_nmi_r && mode_r == MODE0;
      if (ack_last)
      begin
        if (kind_nmi_r)
          service_addr_r <= NMI_ADDR;
        else if (mode_r == MODE1)
          service_addr_r <= RST38_ADDR;
        else if (mode_r == MODE2)
          table_addr_r <= {vbase_r, data_in & TBL_LSB_MASK};
        else
          exec_byte_r <= data_in;
      end
      if (state_r == ST_TABLE && cnt_r == TBL_LO_CYC)
      begin
        service_addr_r[7:0] <= data_in;
        table_addr_r <= table_addr_r + 16'h0001;
      end
      if (state_r == ST_TABLE && cnt_r == TBL_HI_CYC)
        service_addr_r[15:8] <= data_in;
    end
  end

  // ****************
  // register port
  // ****************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        REG_STATUS: reg_rdata_r <= {1'b0, state_r != ST_IDLE, mode_r, nmi_pend_r,
          halted_r, shadow_enable_flop_r, primary_enable_flop_r};
        REG_VBASE: reg_rdata_r <= vbase_r;
        REG_MODE: reg_rdata_r <= {6'h00, mode_r};
        default: reg_rdata_r <= 8'h00;
      endcase
    end
    else
      reg_rdata_r <= 8'h00;
  end

  // ****************
  // outputs
  // ****************
  assign reg_rdata = reg_rdata_r;
  assign halt_ack_n = !halted_r;
  assign force_nop = halted_r;
  assign opcode_fetch_cycle = (state_r == ST_ACK) && !kind_nmi_r;
  assign io_request_strobe_n = !(opcode_fetch_cycle && cnt_r >= IO_WAIT_START);
  assign memory_request_strobe_n = !((state_r == ST_ACK) && kind_nmi_r);
  assign resp_busy = state_r != ST_IDLE;
  assign stack_push = state_r == ST_PUSH;
  assign table_read = state_r == ST_TABLE;
  assign table_addr = table_addr_r;
  assign exec_byte = exec_byte_r;
  assign exec_valid = exec_valid_r;
  assign jump_valid = state_r == ST_JUMP;
  assign service_addr = service_addr_r;
  assign pv_flag = pv_flag_r;
  assign pv_load = pv_load_r;

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_int_ack;
    opcode_fetch_cycle [*7];
  endsequence
  sequence seq_push;
    stack_push [*6];
  endsequence
  sequence seq_table;
    table_read [*6];
  endsequence
  a_nmi_priority: assert property (sample && nmi_pend_r |-> take_nmi && !take_int)
    else $error("unmaskable request lost priority");
  a_nmi_target: assert property (take_nmi |-> ##12 jump_valid && service_addr == NMI_ADDR)
    else $error("unmaskable response wrong target or timing");
  a_halt_ack: assert property (halted_r |-> !halt_ack_n && force_nop)
    else $error("halt ack or no-op missing while halted");
  a_halt_exit: assert property (halted_r && (take_nmi || take_int) |=> !halted_r && resp_busy)
    else $error("halt not left after accepted request");
  a_reset_mode: assert property ($rose(rst_n) |-> mode_r == MODE0 && vbase_r == VBASE_RST)
    else $error("reset state wrong");
  a_enable_delay: assert property (enable_delay_r || enable_irq_instruction |-> !take_int)
    else $error("maskable taken within enable shadow");
  a_int_enable: assert property (take_int |-> primary_enable_flop_r && bus_request_n)
    else $error("maskable taken while blocked");
  a_int_clears: assert property (take_int |=> !primary_enable_flop_r && !shadow_enable_flop_r)
    else $error("enables not cleared on maskable accept");
  a_nmi_shadow: assert property (take_nmi && !disable_irq_instruction |=>
    !primary_enable_flop_r && shadow_enable_flop_r == $past(shadow_enable_flop_r))
    else $error("unmaskable accept mishandled enables");
  a_pv_copy: assert property (load_acc_from_vector_base || load_acc_from_refresh_counter
    |=> pv_load && pv_flag == $past(shadow_enable_flop_r))
    else $error("parity flag not shadow copy");
  a_return_copy: assert property (return_from_unmaskable_service && !take_nmi && !take_int
    && !enable_irq_instruction && !disable_irq_instruction
    |=> primary_enable_flop_r == $past(shadow_enable_flop_r))
    else $error("return did not restore primary enable");
  a_mode1_target: assert property (take_int && mode_r == MODE1
    |-> ##14 jump_valid && service_addr == RST38_ADDR)
    else $error("mode one response wrong");
  a_mode2_len: assert property (take_int && mode_r == MODE2
    |=> seq_int_ack ##1 seq_push ##1 seq_table ##1 jump_valid)
    else $error("mode two response not 19 clocks");
  a_mode0_exec: assert property (take_int && mode_r == MODE0
    |-> ##8 exec_valid && exec_byte == $past(data_in))
    else $error("mode zero byte not delivered");
  a_ack_io: assert property (opcode_fetch_cycle |-> memory_request_strobe_n)
    else $error("memory strobe during maskable ack");
endmodule : cpu_interrupt_response
`default_nettype wire

// ===== logic/irq_resp_pkg.sv
// constants and types of the interrupt response block
`default_nettype none
package irq_resp_pkg;
  // ****************
  // service targets
  // ****************
  localparam logic [15:0] NMI_ADDR = 16'h0066;
  localparam logic [15:0] RST38_ADDR = 16'h0038;
  // ****************
  // cycle counts
  // ****************
  localparam logic [3:0] ACK_INT_CYC = 4'h7;
  localparam logic [3:0] ACK_NMI_CYC = 4'h5;
  localparam logic [3:0] PUSH_CYC = 4'h6;
  localparam logic [3:0] TABLE_CYC = 4'h6;
  localparam logic [3:0] TBL_LO_CYC = 4'h2;
  localparam logic [3:0] TBL_HI_CYC = 4'h5;
  localparam logic [3:0] IO_WAIT_START = 4'h2;
  // ****************
  // response modes
  // ****************
  localparam logic [1:0] MODE0 = 2'h0;
  localparam logic [1:0] MODE1 = 2'h1;
  localparam logic [1:0] MODE2 = 2'h2;
  // ****************
  // register port
  // ****************
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_VBASE = 2'h1;
  localparam logic [1:0] REG_MODE = 2'h2;
  localparam logic [7:0] VBASE_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] TBL_LSB_MASK = 8'hfe;
  localparam int ST_HALTED = 2;
  localparam int ST_NMI_PEND = 3;
  localparam int ST_BUSY = 6;
  // ****************
  // sequencer states
  // ****************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACK = 3'b001,
    ST_PUSH = 3'b010,
    ST_TABLE = 3'b011,
    ST_JUMP = 3'b100
  } resp_state_t;
endpackage : irq_resp_pkg
`default_nettype wire

// ===== tb/peripheral_model.sv
// model of the interrupting peripheral and vector table on the data bus
`timescale 1ns/1ps
`default_nettype none
module peripheral_model
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // acknowledge watch
  input wire logic io_request_strobe_n,
  input wire logic table_read,
  // bytes to supply
  input wire logic [7:0] vec,
  input wire logic [15:0] tbl_word,
  // data bus
  output logic [7:0] data_in
);
  logic [7:0] last_r;
  logic [2:0] tcnt_r;
  // ****************
  // bus drive
  // ****************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_r <= 8'h00;
      tcnt_r <= 3'h0;
    end
    else
    begin
      last_r <= data_in;
      tcnt_r <= table_read ? tcnt_r + 3'h1 : 3'h0;
    end
  end
  // released bus toggles, never holds the last byte
  always_comb
  begin
    if (!io_request_strobe_n)
      data_in = vec;
    else if (table_read)
      data_in = (tcnt_r < 3'h3) ? tbl_word[7:0] : tbl_word[15:8];
    else
      data_in = ~last_r;
  end
endmodule : peripheral_model
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench of the interrupt response block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
`define PULSE(s) begin @(posedge ref_clk); s <= 1'b1; @(posedge ref_clk); s <= 1'b0; end
module testbench;
  import irq_resp_pkg::*;
  logic ref_clk = 1'b0;
  logic clk_run = 1'b1;
  logic rst_n = 1'b0;
  logic int_n = 1'b1, nmi_n = 1'b1, bus_request_n = 1'b1;
  logic instr_last = 1'b0, t4_strobe = 1'b0, halt_exec = 1'b0, mode_set = 1'b0;
  logic enable_irq_instruction = 1'b0, disable_irq_instruction = 1'b0;
  logic return_from_unmaskable_service = 1'b0, load_acc_from_vector_base = 1'b0;
  logic load_acc_from_refresh_counter = 1'b0, load_vector_base = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] mode_sel = 2'h0, reg_addr = 2'h0;
  logic [7:0] acc_in = 8'h00, reg_wdata = 8'h00, vec = 8'h00, rd, data_in, reg_rdata, exec_byte;
  logic [15:0] tbl_word = 16'h0000, tbl_a, table_addr, service_addr;
  logic halt_ack_n, force_nop, opcode_fetch_cycle, io_request_strobe_n;
  logic memory_request_strobe_n, resp_busy, stack_push, table_read, exec_valid, jump_valid;
  logic pv_flag, pv_load;
  int bad_count = 0, compares = 0, n_fetch, n_io, n_mem, n_push;
  // ****************
  // instances
  // ****************
  cpu_interrupt_response cpu_interrupt_response_i (.ref_clk, .rst_n, .int_n, .nmi_n,
    .bus_request_n, .data_in, .instr_last, .t4_strobe, .halt_exec, .enable_irq_instruction,
    .disable_irq_instruction, .return_from_unmaskable_service, .load_acc_from_vector_base,
    .load_acc_from_refresh_counter, .load_vector_base, .acc_in, .mode_set, .mode_sel,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .halt_ack_n, .force_nop,
    .opcode_fetch_cycle, .io_request_strobe_n, .memory_request_strobe_n, .resp_busy,
    .stack_push, .table_read, .table_addr, .exec_byte, .exec_valid, .jump_valid,
    .service_addr, .pv_flag, .pv_load);
  peripheral_model peripheral_model_i (.ref_clk, .rst_n, .io_request_strobe_n, .table_read,
    .vec, .tbl_word, .data_in);
  always #25 if (clk_run) ref_clk = ~ref_clk;
  // ****************
  // shared tasks
  // ****************
  function automatic logic [7:0] st(input logic p, input logic s, input logic [1:0] m);
    return {2'b00, m, 2'b00, s, p};
  endfunction : st
  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic st_chk(input logic [7:0] e);
    reg_read(REG_STATUS, rd);
    `CHK(rd, e)
  endtask : st_chk
  task automatic enable_irqs;
    `PULSE(enable_irq_instruction)
    `PULSE(instr_last)
  endtask : enable_irqs
  // follows a response from the take edge to its final pulse
  task automatic resp(input int en, input logic [15:0] ea);
    int n;
    n_fetch = 0;
    n_io = 0;
    n_mem = 0;
    n_push = 0;
    #1 n = 1;
    while (jump_valid !== 1'b1 && exec_valid !== 1'b1 && n < 40)
    begin
      n_fetch += opcode_fetch_cycle;
      n_io += !io_request_strobe_n;
      n_mem += !memory_request_strobe_n;
      n_push += stack_push;
      if (stack_push)
        tbl_a = table_addr;
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK(n, en)
    `CHK(jump_valid ? service_addr : {8'h00, exec_byte}, ea)
    @(posedge ref_clk);
  endtask : resp
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    `CHK(halt_ack_n, 1'b1)
    st_chk(st(0, 0, 2'h0));
    reg_read(REG_VBASE, rd);
    `CHK(rd, 8'h00)
    reg_read(2'h3, rd);
    `CHK(rd, 8'h00)
  endtask : t_reset
  task automatic t_regs;
    reg_write(REG_STATUS, 8'hff);
    st_chk(st(0, 0, 2'h0));
    reg_write(REG_MODE, 8'h01);
    st_chk(st(0, 0, 2'h1));
    reg_write(REG_MODE, 8'h03);
    st_chk(st(0, 0, 2'h1));
  endtask : t_regs
  task automatic t_mode1;
    @(posedge ref_clk);
    int_n <= 1'b0;
    `PULSE(instr_last)
    #1 `CHK(resp_busy, 1'b0)
    @(posedge ref_clk);
    enable_irq_instruction <= 1'b1;
    instr_last <= 1'b1;
    @(posedge ref_clk);
    enable_irq_instruction <= 1'b0;
    instr_last <= 1'b0;
    #1 `CHK(resp_busy, 1'b0)
    `PULSE(instr_last)
    #1 `CHK(resp_busy, 1'b0)
    st_chk(st(1, 1, 2'h1));
    @(posedge ref_clk);
    bus_request_n <= 1'b0;
    `PULSE(instr_last)
    #1 `CHK(resp_busy, 1'b0)
    @(posedge ref_clk);
    bus_request_n <= 1'b1;
    `PULSE(instr_last)
    resp(14, 16'h0038);
    `CHK(n_fetch, 7)
    `CHK(n_io, 5)
    int_n <= 1'b1;
    st_chk(st(0, 0, 2'h1));
  endtask : t_mode1
  task automatic t_mode2;
    @(posedge ref_clk);
    acc_in <= 8'h12;
    load_vector_base <= 1'b1;
    mode_sel <= MODE2;
    mode_set <= 1'b1;
    vec <= 8'h46;
    tbl_word <= 16'h5634;
    @(posedge ref_clk);
    load_vector_base <= 1'b0;
    mode_set <= 1'b0;
    enable_irqs;
    @(posedge ref_clk);
    int_n <= 1'b0;
    `PULSE(instr_last)
    resp(20, 16'h5634);
    `CHK(tbl_a, 16'h1246)
    `CHK(n_push, 6)
    int_n <= 1'b1;
    reg_read(REG_VBASE, rd);
    `CHK(rd, 8'h12)
  endtask : t_mode2
  task automatic t_mode0;
    @(posedge ref_clk);
    mode_sel <= MODE0;
    mode_set <= 1'b1;
    vec <= 8'hef;
    @(posedge ref_clk);
    mode_set <= 1'b0;
    enable_irqs;
    @(posedge ref_clk);
    int_n <= 1'b0;
    `PULSE(instr_last)
    resp(8, 16'h00ef);
    int_n <= 1'b1;
  endtask : t_mode0
  task automatic t_nmi;
    enable_irqs;
    @(posedge ref_clk);
    nmi_n <= 1'b0;
    int_n <= 1'b0;
    @(posedge ref_clk);
    `PULSE(instr_last)
    resp(12, 16'h0066);
    `CHK(n_mem, 5)
    `CHK(n_fetch, 0)
    nmi_n <= 1'b1;
    int_n <= 1'b1;
    st_chk(st(0, 1, 2'h0));
    `PULSE(load_acc_from_vector_base)
    #1 `CHK({pv_load, pv_flag}, 2'b11)
    `PULSE(return_from_unmaskable_service)
    st_chk(st(1, 1, 2'h0));
    `PULSE(disable_irq_instruction)
    st_chk(st(0, 0, 2'h0));
    `PULSE(load_acc_from_refresh_counter)
    #1 `CHK({pv_load, pv_flag}, 2'b10)
  endtask : t_nmi
  task automatic t_halt;
    enable_irqs;
    `PULSE(halt_exec)
    #1 `CHK({halt_ack_n, force_nop}, 2'b01)
    `PULSE(t4_strobe)
    #1 `CHK({halt_ack_n, resp_busy}, 2'b00)
    clk_run = 1'b0;
    #333 `CHK({halt_ack_n, force_nop}, 2'b01)
    clk_run = 1'b1;
    @(posedge ref_clk);
    nmi_n <= 1'b0;
    int_n <= 1'b0;
    @(posedge ref_clk);
    `PULSE(t4_strobe)
    resp(12, 16'h0066);
    `CHK(n_fetch, 0)
    `CHK(halt_ack_n, 1'b1)
    nmi_n <= 1'b1;
    int_n <= 1'b1;
  endtask : t_halt
  task automatic give_verdict;
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_mode1;
    t_mode2;
    t_mode0;
    t_nmi;
    t_halt;
    give_verdict;
  end
  initial
  begin
    #200000;
    bad_count++;
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
